// File: rtl/seg_pkg.sv
// Shared constants and types for the segment selector translation unit
package seg_pkg;
    // Segment register encodings; the local table register follows the six
    localparam logic [2:0] SEG_EXTRA   = 3'h0;
    localparam logic [2:0] SEG_CODE    = 3'h1;
    localparam logic [2:0] SEG_STACK   = 3'h2;
    localparam logic [2:0] SEG_PRIMARY = 3'h3;
    localparam logic [2:0] SEG_THR_A   = 3'h4;
    localparam logic [2:0] SEG_THR_B   = 3'h5;
    localparam logic [2:0] SEG_LOCAL   = 3'h6;
    localparam int         NUM_SEG     = 7;
    // Selector fields
    localparam int SEL_IDX_MSB = 15;
    localparam int SEL_IDX_LSB = 3;
    localparam int SEL_TI_BIT  = 2;
    localparam int SEL_RPL_MSB = 1;
    localparam logic [2:0] DESC_SCALE_ZERO = 3'h0;
    // System table register selects for the write port
    localparam logic [1:0] SYS_GLOBAL = 2'h0;
    localparam logic [1:0] SYS_INTR   = 2'h1;
    localparam logic [1:0] SYS_TASK   = 2'h2;
    // Reset values and fixed figures
    localparam logic [15:0] SEL_RESET   = 16'h0000;
    localparam logic [31:0] LIMIT_RESET = 32'h0000_ffff;
    localparam logic [1:0]  CPL_RESET   = 2'h0;
    localparam logic [1:0]  CPL_USER    = 2'h3;
    localparam int          CANON_MSB   = 47;

    // Descriptor contents as delivered by the fetch port
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic [1:0]  descriptor_priv_level;
        logic        def_size;
        logic        long_attr;
        logic        present;
    } desc_t;

    // Selector plus hidden portion of one segment register
    typedef struct packed {
        logic [15:0] sel;
        logic [63:0] base;
        logic [31:0] limit;
        logic [1:0]  descriptor_priv_level;
        logic        def_size;
        logic        long_attr;
        logic        valid;
    } hidden_t;

    typedef struct packed {
        logic [63:0] base;
        logic [31:0] limit;
    } sys_reg_t;

    typedef struct packed {
        logic [2:0]  seg;
        logic [15:0] sel;
        logic        priv_ret;
    } load_req_t;
endpackage

// File: rtl/seg_translate.sv
// Segment selector load, descriptor fetch and address translation unit
//
// Summary of operation
// [RULE_01] Each segment has own base and 32-bit limit, one byte to 4 Gbytes.
// [RULE_02] Outside 64-bit mode linear addresses stay within low 4 Gbytes.
// [RULE_03] Flat model: software programs all bases zero, limits 4 Gbytes.
// [RULE_04] 64-bit mode: base taken as zero, limits and attributes ignored.
// [RULE_05] 64-bit mode still uses code privilege, default size, long attr.
// [RULE_06] 64-bit mode: both thread-base segments add their non-zero base.
// [RULE_07] Table and task registers stay in use in every mode.
// [RULE_08] Loading a selector fetches its descriptor into the hidden portion.
// [RULE_09] Index bits 15:3 times eight give descriptor byte offset.
// [RULE_10] Table-select bit 2 picks global or local table base.
// [RULE_11] Index scaled by eight even for 16-byte descriptors.
// [RULE_12] Requestor privilege bits 1:0 are kept with the selector.
// [RULE_13] Index 0 with table bit 0 is null and invalidates the register.
// [RULE_14] Outside 64-bit mode a reference through null selector faults.
// [RULE_15] Null allowed in data registers and local table; code faults.
// [RULE_16] Null stack load faults outside 64-bit mode or at privilege 3.
// [RULE_17] Flag set: null load clears base, limit; not on privileged returns. Code exempts only data registers on those returns.
// [RULE_18] Flag clear: base and limit after null load are left as they were.
// [RULE_19] Table registers hold location and size; task register too.
// [RULE_20] Thread-base selector loads write 32-bit base, upper bits cleared.
// [RULE_21] 64-bit thread-base references check canonical form only.
// [RULE_22] Hidden portion changes only after a successful descriptor fetch or a null load.
`timescale 1ns/100ps
`default_nettype none
module seg_translate (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              long_active_i,
    input  wire logic              null_load_zeroes_base_flag_i,
    input  wire logic              load_valid_i,
    input  wire seg_pkg::load_req_t load_req_i,
    output logic                   load_ready_o,
    output logic                   load_done_o,
    output logic                   general_protection_fault_o,
    output logic                   fetch_req_o,
    output logic [63:0]            fetch_addr_o,
    input  wire logic              fetch_rsp_valid_i,
    input  wire logic              fetch_err_i,
    input  wire seg_pkg::desc_t    fetch_desc_i,
    input  wire logic              sys_wr_i,
    input  wire logic [1:0]        sys_sel_i,
    input  wire seg_pkg::sys_reg_t sys_data_i,
    input  wire logic              ref_valid_i,
    input  wire logic [2:0]        ref_seg_i,
    input  wire logic [63:0]       ref_ea_i,
    output logic                   ref_done_o,
    output logic                   ref_fault_o,
    output logic [63:0]            lin_addr_o,
    input  wire logic [2:0]        rd_seg_i,
    output logic [15:0]            rd_sel_o,
    output logic [1:0]             current_priv_level_o,
    output logic                   def_op32_o,
    output logic                   mode64_o
);
    import seg_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_FETCH = 2'b10
    } state_t;

    state_t      state_reg;
    load_req_t   pend_reg;
    hidden_t     seg_reg [NUM_SEG];
    sys_reg_t    sys_reg [3];
    logic        in_null;
    logic        in_fault;
    logic        in_data;
    logic [63:0] tbase;
    logic        accept;
    logic        commit;

    function automatic logic is_null(input logic [15:0] s);
        return (s[SEL_IDX_MSB:SEL_IDX_LSB] == 13'h0) && !s[SEL_TI_BIT];
    endfunction

    assign accept = (state_reg == ST_IDLE) && load_valid_i;
    assign commit = (state_reg == ST_FETCH) && fetch_rsp_valid_i
                    && !fetch_err_i && fetch_desc_i.present;
    assign in_null = is_null(load_req_i.sel); // RULE_13
    assign in_data = (load_req_i.seg == SEG_EXTRA)
                  || (load_req_i.seg == SEG_PRIMARY)
                  || (load_req_i.seg == SEG_THR_A)
                  || (load_req_i.seg == SEG_THR_B);

    // Null loads are decided without a fetch
    always_comb begin
        in_fault = 1'b0;
        if (in_null) begin
            if (load_req_i.seg == SEG_CODE) begin
                in_fault = 1'b1; // RULE_15
            end else if (load_req_i.seg == SEG_STACK) begin
                in_fault = !mode64_o
                        || (current_priv_level_o == CPL_USER); // RULE_16
            end
        end
    end

    // Local table register itself is always described by the global table
    always_comb begin
        if (load_req_i.sel[SEL_TI_BIT] && load_req_i.seg != SEG_LOCAL) begin
            tbase = seg_reg[SEG_LOCAL].base; // RULE_10
        end else begin
            tbase = sys_reg[SYS_GLOBAL].base; // RULE_10
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            pend_reg  <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept && !in_null) begin
                        state_reg <= ST_FETCH; // RULE_08
                        pend_reg  <= load_req_i;
                    end
                end
                ST_FETCH: begin
                    if (fetch_rsp_valid_i) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Descriptor fetch request held until the response
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fetch_req_o  <= 1'b0;
            fetch_addr_o <= 64'h0;
            load_ready_o <= 1'b0;
        end else begin
            load_ready_o <= !(accept && !in_null)
                         && !(state_reg == ST_FETCH && !fetch_rsp_valid_i);
            if (accept && !in_null) begin
                fetch_req_o  <= 1'b1;
                // 16-byte entries still scale by eight
                fetch_addr_o <= tbase + {48'h0,
                    load_req_i.sel[SEL_IDX_MSB:SEL_IDX_LSB],
                    DESC_SCALE_ZERO}; // RULE_09 RULE_11
            end else if (fetch_rsp_valid_i) begin
                fetch_req_o  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            load_done_o                <= 1'b0;
            general_protection_fault_o <= 1'b0;
        end else begin
            load_done_o                <= (accept && in_null && !in_fault)
                                       || commit;
            general_protection_fault_o <= (accept && in_fault)
                || (state_reg == ST_FETCH && fetch_rsp_valid_i && !commit);
        end
    end

    // Hidden portions; a failed fetch leaves them untouched
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_SEG; i++) begin
                seg_reg[i]       <= '0;
                seg_reg[i].sel   <= SEL_RESET;
                seg_reg[i].limit <= LIMIT_RESET;
            end
        end else if (accept && in_null && !in_fault) begin
            seg_reg[load_req_i.seg].sel   <= load_req_i.sel; // RULE_12
            seg_reg[load_req_i.seg].valid <= 1'b0; // RULE_13
            // Flag clear leaves base and limit alone; 64-bit thread-base references and local-table descriptor fetches still use the base
            if (null_load_zeroes_base_flag_i // RULE_18
                && !(load_req_i.priv_ret && in_data)) begin
                seg_reg[load_req_i.seg].base  <= 64'h0; // RULE_17
                seg_reg[load_req_i.seg].limit <= 32'h0; // RULE_17
            end
        end else if (commit) begin
            seg_reg[pend_reg.seg].sel       <= pend_reg.sel; // RULE_22
            seg_reg[pend_reg.seg].base      <= {32'h0,
                                                fetch_desc_i.base}; // RULE_20
            seg_reg[pend_reg.seg].limit     <= fetch_desc_i.limit; // RULE_01
            seg_reg[pend_reg.seg].descriptor_priv_level       <= fetch_desc_i.descriptor_priv_level;
            seg_reg[pend_reg.seg].def_size  <= fetch_desc_i.def_size;
            seg_reg[pend_reg.seg].long_attr <= fetch_desc_i.long_attr;
            seg_reg[pend_reg.seg].valid     <= 1'b1; // RULE_08
        end
    end

    // Code segment attributes stay live in every mode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            current_priv_level_o <= CPL_RESET;
            def_op32_o           <= 1'b0;
            mode64_o             <= 1'b0;
        end else begin
            if (commit && pend_reg.seg == SEG_CODE) begin
                current_priv_level_o <= fetch_desc_i.descriptor_priv_level; // RULE_05
            end
            def_op32_o <= seg_reg[SEG_CODE].def_size; // RULE_05
            mode64_o   <= long_active_i
                       && seg_reg[SEG_CODE].long_attr; // RULE_05
        end
    end

    // System table and task registers, written directly
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                sys_reg[i] <= '0;
            end
        end else if (sys_wr_i && sys_sel_i <= SYS_TASK) begin
            sys_reg[sys_sel_i] <= sys_data_i; // RULE_07 RULE_19
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_sel_o <= SEL_RESET;
        end else if (rd_seg_i < 3'(NUM_SEG)) begin
            rd_sel_o <= seg_reg[rd_seg_i].sel;
        end else begin
            rd_sel_o <= SEL_RESET;
        end
    end

    // Reference translation, one cycle
    hidden_t     rh;
    logic        r_thread;
    logic [63:0] r_sum;
    logic [31:0] r_off;
    assign rh       = seg_reg[ref_seg_i < 3'(NUM_SEG) ? ref_seg_i : SEG_PRIMARY];
    assign r_thread = (ref_seg_i == SEG_THR_A) || (ref_seg_i == SEG_THR_B);
    assign r_off    = ref_ea_i[31:0];
    assign r_sum    = (r_thread ? rh.base : 64'h0)
                    + ref_ea_i; // RULE_04 RULE_06

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ref_done_o  <= 1'b0;
            ref_fault_o <= 1'b0;
            lin_addr_o  <= 64'h0;
        end else begin
            ref_done_o <= ref_valid_i;
            if (!ref_valid_i) begin
                ref_fault_o <= 1'b0;
            end else if (mode64_o) begin
                lin_addr_o  <= r_sum; // RULE_04 RULE_06
                // Wraps silently; only canonical form is checked
                ref_fault_o <= !((&r_sum[63:CANON_MSB])
                              || !(|r_sum[63:CANON_MSB])); // RULE_21
            end else begin
                lin_addr_o  <= {32'h0, rh.base[31:0] + r_off}; // RULE_02
                ref_fault_o <= !rh.valid // RULE_14
                            || (r_off > rh.limit); // RULE_01
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    null_code_a: assert property ( // RULE_15
        accept && in_null && load_req_i.seg == SEG_CODE
        |=> general_protection_fault_o && !load_done_o)
        else $error("null code load did not fault");
    null_stack_a: assert property ( // RULE_16
        accept && in_null && load_req_i.seg == SEG_STACK
        && (!mode64_o || current_priv_level_o == CPL_USER)
        |=> general_protection_fault_o)
        else $error("null stack load did not fault");
    fetch_addr_a: assert property ( // RULE_09
        accept && !in_null |=> fetch_req_o
        && fetch_addr_o[2:0] == 3'h0
        && fetch_addr_o == $past(tbase) + {48'h0,
           $past(load_req_i.sel[SEL_IDX_MSB:SEL_IDX_LSB]), 3'h0})
        else $error("descriptor address wrong");
    thread_base_a: assert property ( // RULE_20
        commit && (pend_reg.seg == SEG_THR_A || pend_reg.seg == SEG_THR_B)
        |=> seg_reg[$past(pend_reg.seg)].base[63:32] == 32'h0
        && load_done_o)
        else $error("thread base upper bits not cleared");
    keep_hidden_a: assert property ( // RULE_22
        state_reg == ST_FETCH && fetch_rsp_valid_i && !commit
        |=> $stable(seg_reg[pend_reg.seg]) && general_protection_fault_o)
        else $error("faulting load changed hidden portion");
    null_ref_a: assert property ( // RULE_14
        ref_valid_i && !mode64_o && !rh.valid |=> ref_fault_o && ref_done_o)
        else $error("null reference did not fault");
    compat_low_a: assert property ( // RULE_02
        ref_valid_i && !mode64_o |=> lin_addr_o[63:32] == 32'h0)
        else $error("compat address above 4 Gbytes");
    flat64_a: assert property ( // RULE_04
        ref_valid_i && mode64_o && !r_thread
        |=> lin_addr_o == $past(ref_ea_i))
        else $error("64-bit base not treated as zero");
    code_priv_a: assert property ( // RULE_05
        commit && pend_reg.seg == SEG_CODE
        |=> current_priv_level_o == $past(fetch_desc_i.descriptor_priv_level))
        else $error("privilege not taken from code descriptor");
    null_zero_a: assert property ( // RULE_17
        accept && in_null && !in_fault && null_load_zeroes_base_flag_i
        && !(load_req_i.priv_ret && in_data)
        |=> seg_reg[$past(load_req_i.seg)].base == 64'h0
        && !seg_reg[$past(load_req_i.seg)].valid)
        else $error("null load did not clear base");
endmodule // seg_translate
`default_nettype wire

// File: sim/desc_mem_model.sv
// Descriptor memory model answering the unit's fetch port
`timescale 1ns/100ps
`default_nettype none
module desc_mem_model (
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            fetch_req_i,
    input  wire logic [63:0]     fetch_addr_i,
    input  wire logic [3:0]      delay_i,
    input  wire logic            err_cmd_i,
    input  wire logic            absent_cmd_i,
    input  wire logic            flat_cmd_i,
    output logic                 rsp_valid_o,
    output logic                 err_o,
    output seg_pkg::desc_t       desc_o
);
    import seg_pkg::*;
    logic [3:0] wait_reg;
    logic       hold_reg;
    desc_t      d;
    // Contents follow the address so the bench can predict them
    // Flat command plays software that maps one segment over all space
    assign d = '{base: flat_cmd_i ? 32'h0
                       : fetch_addr_i[31:0] + 32'h0001_0000,
                 limit: flat_cmd_i ? 32'hffff_ffff : 32'h0000_0fff,
                 descriptor_priv_level: fetch_addr_i[4:3],
                 def_size: fetch_addr_i[3], long_attr: fetch_addr_i[4],
                 present: !absent_cmd_i};
    // Off the response cycle the lines carry inverted data, never stale data
    assign desc_o = rsp_valid_o ? d : desc_t'(~d);
    assign err_o  = rsp_valid_o ? err_cmd_i : !err_cmd_i;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !fetch_req_i) begin
            wait_reg    <= 4'h0;
            hold_reg    <= 1'b0;
            rsp_valid_o <= 1'b0;
        end else if (rsp_valid_o) begin
            rsp_valid_o <= 1'b0;
            hold_reg    <= 1'b1;
        end else if (!hold_reg && wait_reg == delay_i) begin
            rsp_valid_o <= 1'b1;
        end else if (!hold_reg) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // desc_mem_model
`default_nettype wire

// File: sim/seg_translate_tb.sv
// Self-checking bench for the segment selector translation unit
`timescale 1ns/100ps
`default_nettype none
module seg_translate_tb;
    import seg_pkg::*;
    localparam logic [63:0] GBASE = 64'h0000_0000_0002_0000;
    localparam logic [63:0] LBASE = 64'h0000_0000_0003_0028;
    typedef struct packed {
        logic [2:0]  seg;
        logic [15:0] sel;
        logic [63:0] ea;
        logic        flt;
    } row_t;
    logic        clk = 0, rst_n = 0, long_act = 0, flag = 0;
    logic        load_valid = 0, sys_wr = 0, ref_valid = 0;
    logic        err_cmd = 0, absent_cmd = 0, flat = 0;
    logic        load_ready, load_done, gpf, fetch_req, rsp_valid, ferr;
    logic        ref_done, ref_fault, def32, m64;
    logic [1:0]  sys_sel = 2'h0, current_priv_level;
    logic [2:0]  ref_seg = 3'h0, rd_seg = 3'h0;
    logic [3:0]  dly = 4'h0;
    logic [15:0] rd_sel;
    logic [63:0] fetch_addr, lin, a, ref_ea = 64'h0;
    logic [31:0] b;
    load_req_t   load_req = '0;
    sys_reg_t    sys_data = '0;
    desc_t       fdesc;
    int          errors = 0, n_compared = 0, i;
    row_t        r;
    // Selectors point at first slots of table entries
    row_t rows [6] = '{'{SEG_EXTRA, 16'h0018, 64'h10, 1'b0},
        '{SEG_STACK, 16'h0023, 64'hfff, 1'b0},
        '{SEG_PRIMARY, 16'h002c, 64'h1000, 1'b1},
        '{SEG_THR_A, 16'h0031, 64'h0, 1'b0},
        '{SEG_THR_B, 16'h003e, 64'hffff_0000_0000_0800, 1'b0},
        '{SEG_CODE, 16'h0008, 64'h4, 1'b0}};

    seg_translate seg_translate_i (.clk_i(clk), .rst_n_i(rst_n),
        .long_active_i(long_act), .null_load_zeroes_base_flag_i(flag),
        .load_valid_i(load_valid), .load_req_i(load_req),
        .load_ready_o(load_ready), .load_done_o(load_done),
        .general_protection_fault_o(gpf), .fetch_req_o(fetch_req),
        .fetch_addr_o(fetch_addr), .fetch_rsp_valid_i(rsp_valid),
        .fetch_err_i(ferr), .fetch_desc_i(fdesc), .sys_wr_i(sys_wr),
        .sys_sel_i(sys_sel), .sys_data_i(sys_data), .ref_valid_i(ref_valid),
        .ref_seg_i(ref_seg), .ref_ea_i(ref_ea), .ref_done_o(ref_done),
        .ref_fault_o(ref_fault), .lin_addr_o(lin), .rd_seg_i(rd_seg),
        .rd_sel_o(rd_sel), .current_priv_level_o(current_priv_level), .def_op32_o(def32),
        .mode64_o(m64));
    desc_mem_model desc_mem_model_i (.clk_i(clk), .rst_n_i(rst_n),
        .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr), .delay_i(dly),
        .err_cmd_i(err_cmd), .absent_cmd_i(absent_cmd), .flat_cmd_i(flat),
        .rsp_valid_o(rsp_valid), .err_o(ferr), .desc_o(fdesc));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Inputs always change 1 ns after the edge, so no race with the design
    task automatic load(input logic [2:0] s, input logic [15:0] sl,
                        input logic pr, input logic [63:0] ea,
                        input logic ef);
        int k;
        load_req = '{seg: s, sel: sl, priv_ret: pr};
        load_valid = 1;
        tick();
        load_valid = 0;
        for (k = 0; k < 40 && load_done !== 1'b1 && gpf !== 1'b1; k++) begin
            if (fetch_req === 1'b1) chk(fetch_addr, ea);
            if (fetch_req === 1'b1) chk(load_ready, 0);
            tick();
        end
        if (k == 40) begin
            errors++;
            tally_and_finish();
        end
        chk(gpf, ef);
        chk(load_done, !ef);
        tick();
    endtask

    task automatic refer(input logic [2:0] s, input logic [63:0] ea,
                         input logic ef, input logic [63:0] el);
        ref_seg = s;
        ref_ea = ea;
        ref_valid = 1;
        tick();
        ref_valid = 0;
        chk(ref_done, 1);
        chk(ref_fault, ef);
        if (!ef) chk(lin, el);
        tick();
    endtask

    task automatic rd_chk(input logic [2:0] s, input logic [15:0] exp);
        rd_seg = s;
        tick();
        chk(rd_sel, exp);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1;
        tick();
        chk(load_ready, 1);
        chk(current_priv_level, 0);
        for (i = 0; i < 8; i++) rd_chk(i[2:0], 16'h0000);
        refer(SEG_PRIMARY, 64'h10, 1, 64'h0);
        sys_data = '{base: GBASE, limit: 32'h0000_ffff};
        for (i = 2; i >= 0; i--) begin
            sys_sel = i[1:0];
            sys_wr = 1;
            tick();
        end
        sys_wr = 0;
        load(SEG_LOCAL, 16'h0028, 0, GBASE + 64'h28, 0);
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            r = rows[i];
            a = (r.sel[2] ? LBASE : GBASE) + {48'h0, r.sel[15:3], 3'h0};
            b = a[31:0] + 32'h0001_0000;
            load(r.seg, r.sel, 0, a, 0);
            refer(r.seg, r.ea, r.flt,
                  {32'h0, b + r.ea[31:0]});
            rd_chk(r.seg, r.sel);
        end
        chk(current_priv_level, a[4:3]);
        chk(def32, a[3]);
        $display("test rows done");
        err_cmd = 1;
        load(SEG_PRIMARY, 16'h0010, 0, GBASE + 64'h10, 1);
        err_cmd = 0;
        refer(SEG_PRIMARY, 64'h20, 0, 64'h4_0070);
        rd_chk(SEG_PRIMARY, 16'h002c);
        absent_cmd = 1;
        load(SEG_EXTRA, 16'h0010, 0, GBASE + 64'h10, 1);
        absent_cmd = 0;
        dly = 4'h6;
        load(SEG_EXTRA, 16'h0050, 0, GBASE + 64'h50, 0);
        dly = 4'h0;
        flat = 1;
        load(SEG_PRIMARY, 16'h0010, 0, GBASE + 64'h10, 0);
        flat = 0;
        refer(SEG_PRIMARY, 64'hffff_fff0, 0, 64'hffff_fff0);
        $display("test fetch faults done");
        flag = 1;
        load(SEG_CODE, 16'h0000, 0, 64'h0, 1);
        load(SEG_STACK, 16'h0003, 0, 64'h0, 1);
        load(SEG_PRIMARY, 16'h0002, 0, 64'h0, 0);
        refer(SEG_PRIMARY, 64'h0, 1, 64'h0);
        load(SEG_LOCAL, 16'h0000, 0, 64'h0, 0);
        rd_chk(SEG_CODE, 16'h0008);
        $display("test null loads done");
        long_act = 1;
        load(SEG_CODE, 16'h0010, 0, GBASE + 64'h10, 0);
        tick();
        chk(m64, 1);
        chk(current_priv_level, 2);
        chk(def32, 0);
        refer(SEG_PRIMARY, 64'hffff_8000_0000_0040, 0,
              64'hffff_8000_0000_0040);
        refer(SEG_STACK, 64'h0001_0000_0000_0000, 1, 64'h0);
        refer(SEG_THR_A, 64'h1_0000_0000, 0, 64'h1_0003_0030);
        load(SEG_STACK, 16'h0000, 0, 64'h0, 0);
        load(SEG_THR_A, 16'h0000, 1, 64'h0, 0);
        refer(SEG_THR_A, 64'h8, 0, 64'h3_0038);
        load(SEG_THR_B, 16'h0000, 0, 64'h0, 0);
        refer(SEG_THR_B, 64'h8, 0, 64'h8);
        flag = 0;
        load(SEG_THR_A, 16'h0000, 0, 64'h0, 0);
        refer(SEG_THR_A, 64'h8, 0, 64'h3_0038);
        load(SEG_CODE, 16'h0018, 0, GBASE + 64'h18, 0);
        tick();
        chk(current_priv_level, 3);
        load(SEG_STACK, 16'h0000, 0, 64'h0, 1);
        $display("test long mode done");
        rst_n = 0;
        tick();
        rst_n = 1;
        tick();
        chk(load_ready, 1);
        chk(m64, 0);
        rd_chk(SEG_CODE, 16'h0000);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // seg_translate_tb
`default_nettype wire
